// *** oph_dev_model.sv ***
// Purpose: behavioural display module on the 8080-style write port
// Assumes: host never reads; host releases the bus between writes
// Notes: logs every accepted {dc, byte}; counts pin protocol slips
`default_nettype none
module oph_dev_model
    import oph_pkg::*;
(
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic data_command_select,
    input wire logic chip_init_n,
    input wire logic bus_select_strap_a,
    input wire logic bus_select_strap_b,
    input wire logic [7:0] bus_wire,
    output logic [7:0] dev_drive,
    output int viol_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    oph_byte_s log_q[$];
    logic frame_dc;
    // ==========================================================
    // start values
    initial begin
        dev_drive = 8'h00;
        viol_cnt = 0;
        // idle dc level, so the first select edge out of reset has a reference
        frame_dc = 1'b1;
    end
    // capture at strobe rise, only while selected and out of init
    always @(posedge write_strobe_n) begin
        if (chip_select_n === 1'b0 && chip_init_n === 1'b1) begin
            log_q.push_back({data_command_select, bus_wire});
            dev_drive <= ~bus_wire; // released bus shows the inverse, never the last byte
        end
    end
    // init forgets all command state
    always @(negedge chip_init_n) begin
        log_q.delete();
    end
    // strobe fall needs straps high, read idle, chip selected
    always @(negedge write_strobe_n) begin
        if (read_strobe_n !== 1'b1 || bus_select_strap_a !== 1'b1 ||
            bus_select_strap_b !== 1'b1 || chip_select_n !== 1'b0) begin
            viol_cnt++;
        end
    end
    // dc must not move while selected
    always @(negedge chip_select_n) begin
        frame_dc = data_command_select;
    end
    always @(posedge chip_select_n) begin
        if (data_command_select !== frame_dc) begin
            viol_cnt++;
        end
    end
endmodule // oph_dev_model
`default_nettype wire

// *** oph_host.sv ***
// Purpose: APB-controlled host driving the display module write port
// Assumes: 100 MHz pclk; reads from the module are never issued
// Notes: CTRL starts setup or holds chip init; TXD sends one byte
`default_nettype none
module oph_host
    import oph_pkg::*;
#(
    parameter int RST_CYC = OPH_RST_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic chip_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic data_command_select,
    output logic chip_init_n,
    output logic bus_select_strap_a,
    output logic bus_select_strap_b,
    output logic [7:0] data_out,
    output logic data_oe_n,
    input wire logic [7:0] data_in
);
    typedef enum logic [1:0] {H_RESET, H_IDLE, H_SETUP, H_BYTE} oph_h_e;
    typedef struct packed {
        oph_h_e st;
        logic [31:0] rcnt;
        logic init_n;
        logic done;
        logic byte_req;
        oph_byte_s tx;
        logic [31:0] rdata;
        logic [7:0] din_m;
        logic [7:0] din_s;
    } oph_host_s;
    oph_host_s s_r, s_nxt;
    logic acc, wr_en, rd_en, mapped;
    logic seq_start, seq_req, seq_done, stb_req, stb_ack;
    oph_byte_s seq_byte, stb_byte;
    oph_pins_s pins;

    // ==========================================================
    // apb decode: zero-wait slave, unmapped answers pslverr
    assign acc = psel & penable;
    assign mapped = (paddr == OPH_CTRL_OFS) || (paddr == OPH_STAT_OFS)
        || (paddr == OPH_TXD_OFS);
    assign wr_en = acc & pwrite & mapped;
    assign rd_en = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = s_r.rdata;

    // ==========================================================
    // main control
    always_comb begin
        s_nxt = s_r;
        seq_start = 1'b0;
        // unused readback path is still synchronised
        s_nxt.din_m = data_in;
        s_nxt.din_s = s_r.din_m;
        if (rd_en) begin
            s_nxt.rdata = 32'h0000_0000;
            if (paddr == OPH_STAT_OFS) begin
                s_nxt.rdata[OPH_STAT_BUSY_BIT] = (s_r.st != H_IDLE);
                s_nxt.rdata[OPH_STAT_DONE_BIT] = s_r.done;
                s_nxt.rdata[OPH_STAT_RSTH_BIT] = ~s_r.init_n;
            end else if (paddr == OPH_TXD_OFS) begin
                s_nxt.rdata[7:0] = s_r.din_s;
            end
        end
        case (s_r.st)
            H_RESET: begin
                s_nxt.init_n = 1'b0; // hold chip init low
                if (s_r.rcnt == 32'(RST_CYC - 1)) begin
                    s_nxt.init_n = 1'b1;
                    s_nxt.st = H_IDLE;
                end else begin
                    s_nxt.rcnt = s_r.rcnt + 32'h1;
                end
            end
            H_IDLE: begin
                if (wr_en && paddr == OPH_CTRL_OFS && pwdata[OPH_CTRL_RST_BIT]) begin
                    s_nxt.st = H_RESET; // rerun module init
                    s_nxt.rcnt = 32'h0;
                    s_nxt.init_n = 1'b0;
                    s_nxt.done = 1'b0;
                end else if (wr_en && paddr == OPH_CTRL_OFS
                             && pwdata[OPH_CTRL_INIT_BIT]) begin
                    seq_start = 1'b1;
                    s_nxt.done = 1'b0;
                    s_nxt.st = H_SETUP;
                end else if (wr_en && paddr == OPH_TXD_OFS) begin
                    s_nxt.tx.data = pwdata[7:0];
                    s_nxt.tx.dc = pwdata[OPH_TXD_DC_BIT];
                    s_nxt.byte_req = 1'b1;
                    s_nxt.st = H_BYTE;
                end
            end
            H_SETUP: if (seq_done) begin
                s_nxt.done = 1'b1;
                s_nxt.st = H_IDLE;
            end
            H_BYTE: if (stb_ack) begin
                s_nxt.byte_req = 1'b0;
                s_nxt.st = H_IDLE;
            end
            default: s_nxt.st = H_IDLE;
        endcase
    end

    // ==========================================================
    // share the strobe engine between setup and single bytes
    assign stb_req = (s_r.st == H_SETUP) ? seq_req : s_r.byte_req;
    assign stb_byte = (s_r.st == H_SETUP) ? seq_byte : s_r.tx;

    oph_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .start(seq_start),
        .ack(stb_ack & (s_r.st == H_SETUP)),
        .req(seq_req),
        .req_byte(seq_byte),
        .done(seq_done)
    );

    oph_strobe u_stb (
        .pclk(pclk),
        .presetn(presetn),
        .req(stb_req),
        .req_byte(stb_byte),
        .ack(stb_ack),
        .pins(pins)
    );

    // pins: straps tied high select the 8080 port
    assign bus_select_strap_a = 1'b1;
    assign bus_select_strap_b = 1'b1;
    assign chip_select_n = pins.cs_n;
    assign read_strobe_n = pins.rd_n; // never lowered
    assign write_strobe_n = pins.wr_n;
    assign data_command_select = pins.dc;
    assign data_out = pins.dout;
    assign data_oe_n = pins.d_oe_n;
    assign chip_init_n = s_r.init_n;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: H_RESET, rcnt: 32'h0, init_n: 1'b0, done: 1'b0,
                     byte_req: 1'b0, tx: '0, rdata: 32'h0, din_m: 8'h00, din_s: 8'h00};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // checks
    init_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        !chip_init_n |-> chip_select_n) else $error("port used during init");
    straps_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        bus_select_strap_a && bus_select_strap_b) else $error("strap low");
    rd_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        read_strobe_n) else $error("read strobe lowered");
    setup_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        seq_done |=> s_r.done && s_r.st == H_IDLE) else $error("setup end lost");

    // ==========================================================
    // pin walk of one byte, one phase between each step
    localparam int PH = OPH_PHASE_CYC;
    sequence frame_open_s;
        $fell(chip_select_n);
    endsequence
    sequence write_pulse_s;
        ##PH $fell(write_strobe_n) ##PH $rose(write_strobe_n) ##PH $rose(chip_select_n);
    endsequence
    sequence cmd_lead_s;
        ##PH $fell(chip_select_n);
    endsequence
    byte_walk_a: assert property (@(posedge pclk) disable iff (!presetn)
        frame_open_s |-> write_pulse_s) else $error("byte walk out of step");
    cmd_lead_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(data_command_select) |-> cmd_lead_s) else $error("dc not ahead of select");
    dc_rest_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(chip_select_n) |-> ##PH data_command_select) else $error("dc not back high");
endmodule // oph_host
`default_nettype wire

// *** oph_pkg.sv ***
// Purpose: shared constants and carriers for the display host controller
// Assumes: 100 MHz pclk, APB register access, 8080-style write port
// Notes: offsets are byte addresses of 32-bit words
`default_nettype none
package oph_pkg;
    // ==========================================================
    // register map
    localparam logic [11:0] OPH_CTRL_OFS = 12'h000;
    localparam logic [11:0] OPH_STAT_OFS = 12'h004;
    localparam logic [11:0] OPH_TXD_OFS = 12'h008;
    localparam int OPH_CTRL_INIT_BIT = 0;
    localparam int OPH_CTRL_RST_BIT = 1;
    localparam int OPH_STAT_BUSY_BIT = 0;
    localparam int OPH_STAT_DONE_BIT = 1;
    localparam int OPH_STAT_RSTH_BIT = 2;
    localparam int OPH_TXD_DC_BIT = 8;
    // ==========================================================
    // timing
    localparam int OPH_CLK_MHZ = 100;
    localparam int OPH_CYCLE_NS = 300;
    localparam int OPH_PHASE_CYC = (OPH_CYCLE_NS * OPH_CLK_MHZ / 1000 + 1) / 2;
    localparam int OPH_RST_US = 100;
    localparam int OPH_RST_CYC = OPH_RST_US * OPH_CLK_MHZ;
    // ==========================================================
    // recommended setup: bytes only, dc added by oph_seq
    localparam int OPH_INIT_LEN = 20;
    localparam logic [7:0] OPH_INIT_ROM [OPH_INIT_LEN] = '{
        8'hae, 8'h81, 8'hff, 8'ha8, 8'h1f, 8'ha0, 8'hd3, 8'h20, 8'h40, 8'hc8,
        8'hda, 8'h12, 8'hd9, 8'hf1, 8'hdb, 8'h49, 8'ha4, 8'ha6, 8'haf, 8'h00};
    localparam int OPH_INIT_USED = 19;
    // ==========================================================
    // carriers
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic dc;
        logic [7:0] dout;
        logic d_oe_n;
    } oph_pins_s;
    typedef struct packed {
        logic dc;
        logic [7:0] data;
    } oph_byte_s;
endpackage
`default_nettype wire

// *** oph_seq.sv ***
// Purpose: walks the recommended setup table
// Assumes: start is a one-cycle pulse, host port free
// Notes: emits command bytes only
`default_nettype none
module oph_seq
    import oph_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic ack,
    output logic req,
    output oph_byte_s req_byte,
    output logic done
);
    typedef struct packed {
        logic run;
        logic [4:0] idx;
    } oph_sq_s;
    oph_sq_s s_r, s_nxt;

    // ==========================================================
    // step through table on each acknowledged byte
    always_comb begin
        s_nxt = s_r;
        done = 1'b0;
        if (start) begin
            s_nxt.run = 1'b1;
            s_nxt.idx = 5'h00; // display off first
        end else if (s_r.run && ack) begin
            if (s_r.idx == 5'(OPH_INIT_USED - 1)) begin
                s_nxt.run = 1'b0; // display on last
                done = 1'b1;
            end else begin
                s_nxt.idx = s_r.idx + 5'h01;
            end
        end
    end

    assign req = s_r.run;
    assign req_byte = '{dc: 1'b0, data: OPH_INIT_ROM[s_r.idx]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    first_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        start |=> req && req_byte.data == 8'hae) else $error("first not off");
    cmd_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        req |-> !req_byte.dc) else $error("setup byte not command");
endmodule // oph_seq
`default_nettype wire

// *** oph_strobe.sv ***
// Purpose: one 8080-style write cycle on the display port
// Assumes: caller keeps req until ack
// Notes: each phase lasts OPH_PHASE_CYC cycles from a divider enable
`default_nettype none
module oph_strobe
    import oph_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire oph_byte_s req_byte,
    output logic ack,
    output oph_pins_s pins
);
    typedef enum logic [2:0] {ST_IDLE, ST_DC, ST_CS, ST_WR, ST_RISE, ST_CSUP, ST_END} oph_st_e;
    typedef struct packed {
        oph_st_e st;
        logic [7:0] cnt;
        oph_byte_s b;
        oph_pins_s p;
    } oph_stb_s;
    oph_stb_s s_r, s_nxt;
    logic tick;

    // ==========================================================
    // phase divider: one pulse per half cycle time
    assign tick = (s_r.cnt == 8'(OPH_PHASE_CYC - 1));

    always_comb begin
        s_nxt = s_r;
        ack = 1'b0;
        s_nxt.cnt = tick ? 8'h00 : s_r.cnt + 8'h01;
        case (s_r.st)
            ST_IDLE: begin
                s_nxt.cnt = 8'h00;
                if (req) begin
                    s_nxt.b = req_byte;
                    s_nxt.p.dc = req_byte.dc;
                    s_nxt.st = ST_DC;
                end
            end
            ST_DC: if (tick) begin
                s_nxt.p.cs_n = 1'b0;
                s_nxt.p.rd_n = 1'b1;
                s_nxt.st = ST_CS;
            end
            ST_CS: if (tick) begin
                s_nxt.p.wr_n = 1'b0;
                s_nxt.p.dout = s_r.b.data;
                s_nxt.p.d_oe_n = 1'b0;
                s_nxt.st = ST_WR;
            end
            ST_WR: if (tick) begin
                s_nxt.p.wr_n = 1'b1; // latch edge
                s_nxt.st = ST_RISE;
            end
            ST_RISE: if (tick) begin
                s_nxt.p.cs_n = 1'b1;
                s_nxt.st = ST_CSUP;
            end
            ST_CSUP: if (tick) begin
                s_nxt.p.dc = 1'b1; // dc rests high
                s_nxt.p.d_oe_n = 1'b1;
                s_nxt.st = ST_END;
            end
            ST_END: begin
                ack = 1'b1;
                s_nxt.st = ST_IDLE;
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    assign pins = s_r.p;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: ST_IDLE, cnt: 8'h00, b: '0,
                     p: '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, dc: 1'b1,
                          dout: 8'h00, d_oe_n: 1'b1}};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // checks
    strobe_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(!pins.rd_n && !pins.wr_n)) else $error("both strobes low");
    wr_in_cs_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pins.wr_n) |-> !pins.cs_n) else $error("write edge outside select");
    dc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pins.wr_n |-> pins.dc == s_r.b.dc) else $error("dc moved in write");
    data_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pins.wr_n) |-> !pins.d_oe_n && pins.dout == s_r.b.data)
        else $error("data not driven at latch");
endmodule // oph_strobe
`default_nettype wire

// *** test_oled_parallel_host_port.sv ***
// Purpose: self-checking bench of the APB display host controller
// Assumes: short chip init count, no reads from the module
// Notes: scenarios are tasks; the model logs what reached the module
`default_nettype none
module test_oled_parallel_host_port
    import oph_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RST_N = 20;
    localparam logic [7:0] EXP_SETUP [19] = '{8'hae, 8'h81, 8'hff, 8'ha8, 8'h1f, 8'ha0,
        8'hd3, 8'h20, 8'h40, 8'hc8, 8'hda, 8'h12, 8'hd9, 8'hf1, 8'hdb, 8'h49, 8'ha4,
        8'ha6, 8'haf};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, chip_select_n, read_strobe_n, write_strobe_n;
    logic data_command_select, chip_init_n, bus_select_strap_a, bus_select_strap_b;
    logic [7:0] data_out, dev_drive;
    logic data_oe_n;
    wire logic [7:0] bus_wire;
    int viol_cnt, error_cnt = 0, total_checks = 0;
    // ==========================================================
    // clock, bus level from the host data enable, parts
    always #5 pclk = ~pclk;
    assign bus_wire = (data_oe_n === 1'b0) ? data_out : dev_drive;
    oph_host #(.RST_CYC(RST_N)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .data_command_select(data_command_select),
        .chip_init_n(chip_init_n), .bus_select_strap_a(bus_select_strap_a),
        .bus_select_strap_b(bus_select_strap_b), .data_out(data_out),
        .data_oe_n(data_oe_n), .data_in(bus_wire));
    oph_dev_model u_model (.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .data_command_select(data_command_select),
        .chip_init_n(chip_init_n), .bus_select_strap_a(bus_select_strap_a),
        .bus_select_strap_b(bus_select_strap_b), .bus_wire(bus_wire),
        .dev_drive(dev_drive), .viol_cnt(viol_cnt));
    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer; waits for pready, no assumed latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // poll busy under a bounded count
    task automatic wait_idle;
        logic [31:0] r;
        logic e;
        int n;
        n = 0;
        do begin
            apb(1'b0, OPH_STAT_OFS, 32'h0, r, e);
            n++;
        end while (r[OPH_STAT_BUSY_BIT] !== 1'b0 && n < 5000);
        check({31'h0, r[OPH_STAT_BUSY_BIT]}, 32'h0);
    endtask
    task automatic check_log(input int i, input logic dc, input logic [7:0] b);
        check({23'h0, u_model.log_q[i]}, {23'h0, dc, b});
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        repeat (20) @(posedge pclk);
        check({25'h0, chip_select_n, write_strobe_n, read_strobe_n, data_oe_n, chip_init_n,
            bus_select_strap_a, bus_select_strap_b}, 32'h7b);
        presetn <= 1'b1;
        apb(1'b0, OPH_STAT_OFS, 32'h0, r, e);
        check({29'h0, r[2:0]}, 32'h5);
        wait_idle();
        check({31'h0, chip_init_n}, 32'h1);
    endtask
    task automatic t_setup;
        logic [31:0] r;
        logic e;
        apb(1'b1, OPH_CTRL_OFS, 32'h1 << OPH_CTRL_INIT_BIT, r, e);
        wait_idle();
        apb(1'b0, OPH_STAT_OFS, 32'h0, r, e);
        check({31'h0, r[OPH_STAT_DONE_BIT]}, 32'h1);
        check(u_model.log_q.size(), 32'd19);
        for (int i = 0; i < 19; i++) begin
            check_log(i, 1'b0, EXP_SETUP[i]);
        end
    endtask
    task automatic t_bytes;
        logic [31:0] r;
        logic e;
        int base;
        base = u_model.log_q.size();
        apb(1'b1, OPH_TXD_OFS, 32'h15a, r, e);
        wait_idle();
        apb(1'b1, OPH_TXD_OFS, 32'h0a5, r, e);
        apb(1'b1, OPH_TXD_OFS, 32'h13c, r, e); // busy, must be dropped
        wait_idle();
        check(u_model.log_q.size(), base + 2);
        check_log(base, 1'b1, 8'h5a);
        check_log(base + 1, 1'b0, 8'ha5);
        apb(1'b0, OPH_TXD_OFS, 32'h0, r, e);
        check({24'h0, r[7:0]}, 32'h5a);
    endtask
    task automatic t_unmapped;
        logic [31:0] r;
        logic e;
        apb(1'b0, 12'h00c, 32'h0, r, e);
        check({31'h0, e}, 32'h1);
        apb(1'b0, OPH_STAT_OFS, 32'h0, r, e);
        check({31'h0, e}, 32'h0);
    endtask
    task automatic t_reinit;
        logic [31:0] r;
        logic e;
        apb(1'b1, OPH_CTRL_OFS, 32'h1 << OPH_CTRL_RST_BIT, r, e);
        wait_idle();
        check(u_model.log_q.size(), 32'd0);
        check({31'h0, chip_init_n}, 32'h1);
        apb(1'b1, OPH_TXD_OFS, 32'h0ae, r, e);
        wait_idle();
        check(u_model.log_q.size(), 32'd1);
        check_log(0, 1'b0, 8'hae);
    endtask
    // ==========================================================
    // verdict, watchdog, main sequence
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge pclk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        t_reset();
        t_setup();
        t_bytes();
        t_unmapped();
        t_reinit();
        check(viol_cnt, 32'd0);
        print_verdict();
    end
endmodule // test_oled_parallel_host_port
`default_nettype wire
